// ### hw/fbd_pkg.sv
// shared constants and types for the 4-bit core decode and execute block
package fbd_pkg;
  // widths
  localparam int PC_W   = 14;
  localparam int WORD_W = 10;
  localparam int NIB_W  = 4;
  localparam int RAM_AW = 10;
  localparam int W_W    = 2;

  // values after reset
  localparam logic [PC_W-1:0]  PC_RST     = 14'h0000;
  localparam logic             STATUS_RST = 1'b1;
  localparam logic [NIB_W-1:0] NIB_RST    = 4'h0;
  localparam logic [W_W-1:0]   W_RST      = 2'h0;

  // field positions
  localparam int PAGE_LSB    = 8;
  localparam int ZP_W        = 6;
  localparam int PAT_ACC_BIT = 8;
  localparam int PAT_OUT_BIT = 9;

  // opcode patterns, matched on the upper bits of the word
  localparam logic [1:0] OP_IN_PAGE     = 2'h3;  // word[9:8]
  localparam logic [3:0] OP_CAL         = 4'h7;  // word[9:6]
  localparam logic [5:0] OP_TABLE       = 6'h0b; // word[9:4]
  localparam logic [5:0] OP_PATTERN     = 6'h1b;
  localparam logic [5:0] OP_LAI         = 6'h23;
  localparam logic [5:0] OP_LBI         = 6'h20;
  localparam logic [5:0] OP_STORE_IMM_INC_Y       = 6'h29;
  localparam logic [5:0] OP_LWI         = 6'h0f;
  localparam logic [5:0] OP_LONG_JUMP   = 6'h15;
  localparam logic [5:0] OP_LONG_BRANCH = 6'h17;
  localparam logic [7:0] OP_LAM         = 8'h24; // word[9:2], then y x
  localparam logic [7:0] OP_LBM         = 8'h10;
  localparam logic [7:0] OP_LMA         = 8'h25;
  localparam logic [7:0] OP_XMA         = 8'h20;
  localparam logic [7:0] OP_XMB         = 8'h30;
  localparam logic [8:0] OP_ST_INC      = 9'h028; // word[9:1], then x
  localparam logic [8:0] OP_ST_DEC      = 9'h068;
  localparam logic [9:0] OP_SWAP_X      = 10'h001;
  localparam logic [9:0] OP_SWAP_Y      = 10'h002;
  localparam logic [9:0] OP_SWAP_XY     = 10'h003;
  localparam logic [9:0] OP_ADC         = 10'h018;
  localparam logic [9:0] OP_SBC         = 10'h098;
  localparam logic [9:0] OP_ROR         = 10'h0a0;
  localparam logic [9:0] OP_ROL         = 10'h0a1;
  localparam logic [9:0] OP_XMAD        = 10'h1a0;

  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_ROR, ALU_ROL} fbd_alu_op_e;
  typedef enum {ST_FETCH, ST_OPER, ST_WAIT, ST_EXEC} fbd_state_e;
endpackage

// ### hw/fbd_alu_if.sv
// operand and result bundle between the core and its nibble alu
`timescale 1ns/1ps
interface fbd_alu_if;
  import fbd_pkg::*;
  fbd_alu_op_e      op;
  logic [NIB_W-1:0] opA;
  logic [NIB_W-1:0] opB;
  logic             carryIn;
  logic [NIB_W-1:0] res;
  logic             carryOut;
  modport core (output op, output opA, output opB, output carryIn, input res, input carryOut);
  modport alu  (input op, input opA, input opB, input carryIn, output res, output carryOut);
endinterface

// ### hw/fbd_alu.sv
// nibble alu: add and subtract with carry, rotate through carry
`timescale 1ns/1ps
module fbd_alu
  import fbd_pkg::*;
(
  // operands and results
  fbd_alu_if.alu bus
);
  logic [NIB_W:0] sum;
  logic [NIB_W:0] diff;

  // carry out of sum is overflow; top bit of diff is the borrow
  assign sum  = {1'b0, bus.opA} + {1'b0, bus.opB} + {4'h0, bus.carryIn};
  assign diff = {1'b0, bus.opA} - {1'b0, bus.opB} - {4'h0, ~bus.carryIn};

  // result select; all four codes are legal
  always_comb begin
    unique case (bus.op)
      ALU_ADD: begin
        bus.res      = sum[NIB_W-1:0];
        bus.carryOut = sum[NIB_W];
      end
      ALU_SUB: begin
        bus.res      = diff[NIB_W-1:0];
        bus.carryOut = ~diff[NIB_W];
      end
      ALU_ROR: begin
        bus.res      = {bus.carryIn, bus.opA[NIB_W-1:1]};
        bus.carryOut = bus.opA[0];
      end
      ALU_ROL: begin
        bus.res      = {bus.opA[NIB_W-2:0], bus.carryIn};
        bus.carryOut = bus.opA[NIB_W-1];
      end
    endcase
  end
endmodule

// ### hw/fbd_core.sv
// 4-bit core: branch address forming, pattern fetch and register/alu execute
//
// Notes on behaviour
// - in-page jump replaces pc bits 7..0 only
// - zero-page call loads bits 5..0, clears rest
// - table jump target from operand, b, acc
// - pattern bit 8 loads acc and b
// - pattern bit 9 loads both port outputs
// - pattern leaves pc at its normal advance
// - immediate loads of acc and b, one cycle
// - store immediate, step y, status nonzero
// - load w from immediate, one cycle
// - swap x, y or both with saved copies
// - ram-register ops swap per y x bits
// - store acc, step y, optional x swap
// - memory-acc exchange, direct and indirect forms
// - add with carry, status on overflow
// - subtract with borrow, status when no borrow
// - rotate acc through carry, one cycle
// - 14-bit pc, long forms load all bits
// - direct forms address ram by second word
// - zero-page call only on status, two cycles
`timescale 1ns/1ps
module fbd_core
  import fbd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // program memory, asynchronous read
  output logic [PC_W-1:0]        romAddr,
  input  wire logic [WORD_W-1:0] romData,
  // data memory, asynchronous read, write on the edge after ramWe rises
  output logic [RAM_AW-1:0]      ramAddr,
  output logic [NIB_W-1:0]       ramWdata,
  output logic                   ramWe,
  input  wire logic [NIB_W-1:0]  ramRdata,
  // port output registers loaded by the pattern instruction
  output logic [NIB_W-1:0]       patternOutLow,
  output logic [NIB_W-1:0]       patternOutHigh,
  // visible core state
  output logic [NIB_W-1:0]       acc,
  output logic [NIB_W-1:0]       bReg,
  output logic                   status,
  output logic                   carry
);
  fbd_state_e       state;
  logic [PC_W-1:0]  pc;
  logic [WORD_W-1:0] ir;
  logic [WORD_W-1:0] word2;
  logic [WORD_W-1:0] patWord;
  logic [NIB_W-1:0] xReg;
  logic [NIB_W-1:0] yReg;
  logic [W_W-1:0]   wReg;
  logic [NIB_W-1:0] savedX;
  logic [NIB_W-1:0] savedY;

  fbd_alu_if aluBus ();

  fbd_alu u_alu (
    .bus (aluBus)
  );

  // table address: operand on top, then b, then acc
  function automatic logic [PC_W-1:0] tableAddr(input logic [NIB_W-1:0] p,
                                                input logic [NIB_W-1:0] b,
                                                input logic [NIB_W-1:0] a);
    return {2'b00, p, b, a};
  endfunction

  // words that carry a second word after the opcode
  function automatic logic isTwoWord(input logic [WORD_W-1:0] w);
    return (w == OP_XMAD) || (w[9:4] == OP_LONG_JUMP) || (w[9:4] == OP_LONG_BRANCH);
  endfunction

  // one-word instructions that need a second machine cycle
  function automatic logic isSlow(input logic [WORD_W-1:0] w);
    return (w[9:4] == OP_PATTERN) || (w[9:6] == OP_CAL);
  endfunction

  // opcode decode of the held instruction word
  logic isInPage, isCal, isTbr, isPat, isLai, isLbi, isLmiiy, isLwi;
  logic isJmpl, isBrl, isLam, isLbm, isLma, isXma, isXmb, isStInc, isStDec;
  logic isSwapX, isSwapY, isSwapXY, isAdc, isSbc, isRor, isRol, isXmad;
  assign isInPage = ir[9:8] == OP_IN_PAGE;
  assign isCal    = ir[9:6] == OP_CAL;
  assign isTbr    = ir[9:4] == OP_TABLE;
  assign isPat    = ir[9:4] == OP_PATTERN;
  assign isLai    = ir[9:4] == OP_LAI;
  assign isLbi    = ir[9:4] == OP_LBI;
  assign isLmiiy  = ir[9:4] == OP_STORE_IMM_INC_Y;
  assign isLwi    = ir[9:4] == OP_LWI;
  assign isJmpl   = ir[9:4] == OP_LONG_JUMP;
  assign isBrl    = ir[9:4] == OP_LONG_BRANCH;
  assign isLam    = ir[9:2] == OP_LAM;
  assign isLbm    = ir[9:2] == OP_LBM;
  assign isLma    = ir[9:2] == OP_LMA;
  assign isXma    = ir[9:2] == OP_XMA;
  assign isXmb    = ir[9:2] == OP_XMB;
  assign isStInc  = ir[9:1] == OP_ST_INC;
  assign isStDec  = ir[9:1] == OP_ST_DEC;
  assign isSwapX  = ir == OP_SWAP_X;
  assign isSwapY  = ir == OP_SWAP_Y;
  assign isSwapXY = ir == OP_SWAP_XY;
  assign isAdc    = ir == OP_ADC;
  assign isSbc    = ir == OP_SBC;
  assign isRor    = ir == OP_ROR;
  assign isRol    = ir == OP_ROL;
  assign isXmad   = ir == OP_XMAD;

  // grouped decode
  logic execNow, memRegOp, yStep, aluOp, swX, swY, patToAcc, patToOut, wrEn;
  logic [NIB_W-1:0] imm;
  assign execNow  = state == ST_EXEC;
  assign imm      = ir[NIB_W-1:0];
  assign memRegOp = isLam | isLbm | isLma | isXma | isXmb;
  assign yStep    = isLmiiy | isStInc | isStDec;
  assign aluOp    = isAdc | isSbc | isRor | isRol;
  assign swX      = isSwapX | isSwapXY | (memRegOp & ir[0]) | ((isStInc | isStDec) & ir[0]);
  assign swY      = isSwapY | isSwapXY | (memRegOp & ir[1]);
  assign patToAcc = isPat & patWord[PAT_ACC_BIT];
  assign patToOut = isPat & patWord[PAT_OUT_BIT];
  assign wrEn     = isLmiiy | isLma | isStInc | isStDec | isXma | isXmb | isXmad;

  // alu operand steering; y stepping reuses the adder so no second one is needed
  assign aluBus.op      = (isSbc | isStDec) ? ALU_SUB : isRor ? ALU_ROR : isRol ? ALU_ROL : ALU_ADD;
  assign aluBus.opA     = yStep ? yReg : (isRor | isRol) ? acc : ramRdata;
  assign aluBus.opB     = isStDec ? 4'h1 : yStep ? 4'h0 : acc;
  assign aluBus.carryIn = yStep ? 1'b1 : carry;

  // next register values, applied only in the execute state
  logic [NIB_W-1:0] next_acc, next_b, next_x, next_y, next_wdata;
  logic [W_W-1:0]   next_w;
  logic             next_status, next_carry;
  assign next_acc = isLai ? imm
                  : (isLam | isXma | isXmad) ? ramRdata
                  : aluOp ? aluBus.res
                  : patToAcc ? patWord[NIB_W-1:0]
                  : acc;
  assign next_b = isLbi ? imm
                : (isLbm | isXmb) ? ramRdata
                : patToAcc ? patWord[2*NIB_W-1:NIB_W]
                : bReg;
  assign next_x = swX ? savedX : xReg;
  assign next_y = yStep ? aluBus.res : swY ? savedY : yReg;
  assign next_w = isLwi ? imm[W_W-1:0] : wReg;
  // step results give nonzero or no-borrow; add and subtract give carry out, rotates and all others give one
  assign next_status = (isLmiiy | isStInc) ? (aluBus.res != 4'h0)
                     : (isStDec | isAdc | isSbc) ? aluBus.carryOut
                     : 1'b1;
  assign next_carry = aluOp ? aluBus.carryOut : carry;
  assign next_wdata = isLmiiy ? imm : isXmb ? bReg : acc;

  // branch target; status is the one left by the previous instruction
  logic [PC_W-1:0] next_pc;
  assign next_pc = (isInPage & status) ? {pc[PC_W-1:PAGE_LSB], ir[PAGE_LSB-1:0]}
                 : (isCal & status) ? {{(PC_W-ZP_W){1'b0}}, ir[ZP_W-1:0]}
                 : isTbr ? tableAddr(imm, bReg, acc)
                 : (isJmpl | (isBrl & status)) ? {imm, word2}
                 : pc;

  // sequencer: fetch, optional second word or wait, then execute
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_FETCH;
    end else begin
      unique case (state)
        ST_FETCH: state <= isTwoWord(romData) ? ST_OPER : isSlow(romData) ? ST_WAIT : ST_EXEC;
        ST_OPER:  state <= ST_EXEC;
        ST_WAIT:  state <= ST_EXEC;
        ST_EXEC:  state <= ST_FETCH;
      endcase
    end
  end

  // program counter and program memory address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc      <= PC_RST;
      romAddr <= PC_RST;
    end else if (state == ST_FETCH) begin
      pc      <= pc + 14'h0001;
      romAddr <= isSlow(romData) ? tableAddr(romData[NIB_W-1:0], bReg, acc) : pc + 14'h0001;
    end else if (state == ST_OPER) begin
      pc      <= pc + 14'h0001;
    end else if (execNow) begin
      pc      <= next_pc;
      romAddr <= next_pc;
    end
  end

  // instruction, second word and pattern word holding registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir      <= '0;
      word2   <= '0;
      patWord <= '0;
    end else begin
      if (state == ST_FETCH) ir <= romData;
      if (state == ST_OPER) word2 <= romData;
      if (state == ST_WAIT) patWord <= romData; // the fetch only feeds data, never the pc
    end
  end

  // ram address: indirect at fetch, overridden by the second word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ramAddr <= '0;
    end else if (state == ST_FETCH) begin
      ramAddr <= {wReg, xReg, yReg};
    end else if (state == ST_OPER) begin
      ramAddr <= romData;
    end
  end

  // ram write strobe lasts exactly one clock, during the next fetch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ramWe    <= 1'b0;
      ramWdata <= NIB_RST;
    end else begin
      ramWe    <= execNow & wrEn;
      if (execNow) ramWdata <= next_wdata;
    end
  end

  // working registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc    <= NIB_RST;
      bReg   <= NIB_RST;
      xReg   <= NIB_RST;
      yReg   <= NIB_RST;
      wReg   <= W_RST;
      savedX <= NIB_RST;
      savedY <= NIB_RST;
      status <= STATUS_RST;
      carry  <= 1'b0;
    end else if (execNow) begin
      acc    <= next_acc;
      bReg   <= next_b;
      xReg   <= next_x;
      yReg   <= next_y;
      wReg   <= next_w;
      savedX <= swX ? xReg : savedX;
      savedY <= swY ? yReg : savedY;
      status <= next_status;
      carry  <= next_carry;
    end
  end

  // port output registers; both halves load together
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      patternOutLow  <= NIB_RST;
      patternOutHigh <= NIB_RST;
    end else if (execNow && patToOut) begin
      patternOutLow  <= patWord[NIB_W-1:0];
      patternOutHigh <= patWord[2*NIB_W-1:NIB_W];
    end
  end

  // checks of the execute results
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_in_page;
    execNow && isInPage && status |=> pc[7:0] == $past(ir[7:0]) && pc[13:8] == $past(pc[13:8]);
  endproperty
  a_in_page: assert property (p_in_page) else $error("in-page jump target wrong");

  property p_cal;
    state == ST_FETCH && romData[9:6] == OP_CAL && status |=> state == ST_WAIT ##1 1'b1 ##1
      pc == {8'h00, $past(ir[5:0], 2)};
  endproperty
  a_cal: assert property (p_cal) else $error("zero-page call target or timing wrong");

  property p_tbr;
    execNow && isTbr |=> pc == {2'b00, $past(ir[3:0]), $past(bReg), $past(acc)};
  endproperty
  a_tbr: assert property (p_tbr) else $error("table jump target wrong");

  property p_pattern;
    execNow && isPat |=> pc == $past(pc) && (!$past(patWord[8]) || {bReg, acc} == $past(patWord[7:0]))
      && (!$past(patWord[9]) || {patternOutHigh, patternOutLow} == $past(patWord[7:0]));
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern result wrong");

  property p_lai;
    state == ST_FETCH && romData[9:4] == OP_LAI |=> ##1 acc == $past(romData[3:0], 2) && state == ST_FETCH;
  endproperty
  a_lai: assert property (p_lai) else $error("immediate acc load wrong");

  property p_store_imm_inc_y;
    execNow && isLmiiy |=> ramWe && ramWdata == $past(imm) && yReg == $past(yReg) + 4'h1
      && status == (yReg != 4'h0);
  endproperty
  a_store_imm_inc_y: assert property (p_store_imm_inc_y) else $error("store immediate step wrong");

  property p_swap;
    execNow && isSwapXY |=> xReg == $past(savedX) && savedX == $past(xReg) && yReg == $past(savedY)
      && acc == $past(acc) && status;
  endproperty
  a_swap: assert property (p_swap) else $error("index swap wrong");

  property p_adc;
    execNow && isAdc |=> {status, acc} == {1'b0, $past(ramRdata)} + {1'b0, $past(acc)} + {4'h0, $past(carry)};
  endproperty
  a_adc: assert property (p_adc) else $error("add with carry wrong");

  property p_xmad;
    state == ST_FETCH && romData == OP_XMAD |=> state == ST_OPER ##1 ramAddr == $past(romData) && execNow;
  endproperty
  a_xmad: assert property (p_xmad) else $error("direct exchange address wrong");

  property p_long;
    execNow && (isJmpl || (isBrl && status)) |=> pc == {$past(ir[3:0]), $past(word2)};
  endproperty
  a_long: assert property (p_long) else $error("long jump target wrong");

  property p_lwi;
    execNow && isLwi |=> wReg == $past(ir[1:0]) && status;
  endproperty
  a_lwi: assert property (p_lwi) else $error("w load wrong");

  property p_mem_reg_swap;
    execNow && memRegOp |=> yReg == ($past(ir[1]) ? $past(savedY) : $past(yReg))
      && xReg == ($past(ir[0]) ? $past(savedX) : $past(xReg));
  endproperty
  a_mem_reg_swap: assert property (p_mem_reg_swap) else $error("ram-register index swap wrong");

  property p_st_dec;
    execNow && isStDec |=> ramWe && ramWdata == $past(acc) && yReg == $past(yReg) - 4'h1
      && status == ($past(yReg) != 4'h0) && xReg == ($past(ir[0]) ? $past(savedX) : $past(xReg));
  endproperty
  a_st_dec: assert property (p_st_dec) else $error("store and decrement wrong");

  property p_sbc;
    execNow && isSbc |=> {~status, acc}
      == {1'b0, $past(ramRdata)} - {1'b0, $past(acc)} - {4'h0, ~$past(carry)};
  endproperty
  a_sbc: assert property (p_sbc) else $error("subtract with borrow wrong");

  property p_rotate;
    execNow && (isRor || isRol) |=> status && ($past(isRol) ? {carry, acc} == {$past(acc), $past(carry)}
      : {acc, carry} == {$past(carry), $past(acc)});
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate through carry wrong");
endmodule

// ### tb/tb_top.sv
// self-checking bench for the 4-bit core decode and execute block
`timescale 1ns/1ps
module tb_top;
  import fbd_pkg::*;
  typedef struct {string nm; int sel; logic [13:0] exp;} fbd_note_s;
  logic              clk;
  logic              sys_rst;
  logic [PC_W-1:0]   romAddr;
  logic [WORD_W-1:0] romData;
  logic [RAM_AW-1:0] ramAddr;
  logic [NIB_W-1:0]  ramWdata;
  logic              ramWe;
  logic [NIB_W-1:0]  ramRdata;
  logic [NIB_W-1:0]  patternOutLow;
  logic [NIB_W-1:0]  patternOutHigh;
  logic [NIB_W-1:0]  acc;
  logic [NIB_W-1:0]  bReg;
  logic              status;
  logic              carry;
  logic [WORD_W-1:0] rom [2**PC_W];
  logic [NIB_W-1:0]  mem [2**RAM_AW];
  logic [NIB_W-1:0]  bm [2**RAM_AW];
  fbd_note_s         notes [$];
  fbd_note_s         nt;
  logic [31:0]       rs, r;
  logic [PC_W-1:0]   pc, ta;
  logic [NIB_W-1:0]  a, b, x, y, sx, sy, pl, ph, v;
  logic [1:0]        w;
  logic [9:0]        ad;
  logic [4:0]        sum;
  logic              st, ca;
  int                fails, checked, cycles, k;

  fbd_core i_dut (
    .clk(clk), .sys_rst(sys_rst), .romAddr(romAddr), .romData(romData), .ramAddr(ramAddr),
    .ramWdata(ramWdata), .ramWe(ramWe), .ramRdata(ramRdata), .patternOutLow(patternOutLow),
    .patternOutHigh(patternOutHigh), .acc(acc), .bReg(bReg), .status(status), .carry(carry)
  );

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // memories answer just after the falling edge, well before the sampling edge
  always @(negedge clk) begin
    #1;
    romData = rom[romAddr];
    ramRdata = mem[ramAddr];
  end
  always @(posedge clk) begin
    if (ramWe === 1'b1) mem[ramAddr] <= ramWdata;
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [9:0] adr();
    return {w, x, y};
  endfunction

  function automatic logic [13:0] seen(input int sel);
    case (sel)
      0: return {10'h0, acc};
      1: return {10'h0, bReg};
      2: return {13'h0, status};
      3: return {13'h0, carry};
      4: return romAddr;
      5: return {10'h0, patternOutLow};
      6: return {10'h0, patternOutHigh};
      7: return {13'h0, ramWe};
      8: return {10'h0, ramWdata};
      default: return {4'h0, ramAddr};
    endcase
  endfunction

  task automatic check(input string nm, input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic note(input string nm, input int sel, input logic [13:0] exp);
    notes.push_back('{nm, sel, exp});
  endtask

  // watcher: outputs are settled two ns after the falling edge, so notes are judged then
  always @(negedge clk) begin
    #2;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      check(nt.nm, seen(nt.sel), nt.exp);
    end
  end

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("[FAIL] cycles expected below 3000 seen 3000");
      results();
    end
  end

  // places a word (and a second word) at pc, lets it run, then expects the next fetch address
  task automatic run(input logic [9:0] w0, input logic [9:0] w1, input int n, input logic [13:0] np);
    rom[pc] = w0;
    rom[pc + 14'h1] = w1;
    repeat (n) @(negedge clk);
    pc = np;
    note("romAddr", 4, pc);
  endtask

  task automatic op(input logic [9:0] w0);
    run(w0, 10'h0, 2, pc + 14'h1);
  endtask

  task automatic stored(input logic [3:0] d, input logic [9:0] at);
    note("ramWe", 7, 14'h1);
    note("ramWdata", 8, d);
    note("ramAddr", 9, at);
    bm[at] = d;
  endtask

  task automatic swp(input logic [1:0] yx);
    if (yx[0]) {x, sx} = {sx, x};
    if (yx[1]) {y, sy} = {sy, y};
  endtask

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask

  // main sequence
  initial begin
    rs = 32'hb896;
    sys_rst = 1'b1;
    fails = 0;
    checked = 0;
    cycles = 0;
    foreach (rom[i]) rom[i] = '0;
    foreach (mem[i]) begin
      r = rnd();
      mem[i] = r[3:0];
      bm[i] = r[3:0];
    end
    {pc, a, b, x, y, sx, sy, pl, ph, w, ca} = '0;
    st = 1'b1;
    repeat (9) @(negedge clk);
    for (k = 0; k < 8; k++) note("reset", k, (k == 2));
    @(negedge clk);
    sys_rst = 1'b0;
    tend("reset");
    run({OP_LONG_JUMP, 4'h8}, 10'h0ff, 3, 14'h20ff);
    run({OP_IN_PAGE, 8'h40}, 10'h0, 2, 14'h2140);
    tend("jumps");
    for (k = 0; k < 4; k++) begin
      r = rnd();
      a = r[3:0];
      b = r[7:4];
      op({OP_LAI, a});
      note("acc", 0, a);
      op({OP_LBI, b});
      note("bReg", 1, b);
      note("status", 2, 14'h1);
    end
    tend("immediates");
    r = rnd();
    w = r[1:0];
    op({OP_LWI, 2'b00, w});
    for (k = 0; k < 16; k++) begin
      r = rnd();
      ad = adr();
      y = y + 4'h1;
      st = (y != 4'h0);
      op({OP_STORE_IMM_INC_Y, r[3:0]});
      stored(r[3:0], ad);
      note("status", 2, st);
    end
    op({OP_IN_PAGE, 8'h00});
    tend("store immediate");
    // swap selection cycles through x, y and both
    for (k = 0; k < 6; k++) begin
      r = (k % 3) + 1;
      swp(r[1:0]);
      op({8'h00, r[1:0]});
      ad = adr();
      y = y + 4'h1;
      op({OP_ST_INC, 1'b0});
      stored(a, ad);
    end
    for (k = 0; k < 6; k++) begin
      ad = adr();
      st = (y != 4'h0);
      y = y - 4'h1;
      swp({1'b0, k[0]});
      op({OP_ST_DEC, k[0]});
      stored(a, ad);
      note("status", 2, st);
      // with status low the long branch must fall through to the word after its operand
      if (!st) run({OP_LONG_BRANCH, 4'h3}, 10'h155, 3, pc + 14'h2);
    end
    for (k = 0; k < 4; k++) begin
      r = rnd();
      a = r[3:0];
      op({OP_LAI, a});
      ad = adr();
      swp(k[1:0]);
      op({OP_LMA, k[1:0]});
      stored(a, ad);
      a = bm[adr()];
      swp(k[1:0]);
      op({OP_LAM, k[1:0]});
      note("acc", 0, a);
    end
    tend("index swaps");
    for (k = 0; k < 8; k++) begin
      r = rnd();
      op({OP_LAI, r[3:0]});
      ad = adr();
      op({OP_LMA, 2'b00});
      stored(r[3:0], ad);
      a = r[7:4];
      op({OP_LAI, a});
      if (k[0]) begin
        sum = {1'b0, r[3:0]} - {1'b0, a} - {4'h0, ~ca};
        ca = ~sum[4];
        op(OP_SBC);
      end else begin
        sum = {1'b0, r[3:0]} + {1'b0, a} + {4'h0, ca};
        ca = sum[4];
        op(OP_ADC);
      end
      a = sum[3:0];
      note("acc", 0, a);
      note("carry", 3, ca);
      note("status", 2, ca);
      if (k[1]) begin
        {a, ca} = {ca, a};
        op(OP_ROR);
      end else begin
        {ca, a} = {a, ca};
        op(OP_ROL);
      end
      note("acc", 0, a);
      note("carry", 3, ca);
      note("status", 2, 14'h1);
    end
    tend("arithmetic");
    r = rnd();
    ad = adr();
    op({OP_LAI, r[3:0]});
    a = bm[ad];
    op({OP_XMA, 2'b00});
    stored(r[3:0], ad);
    note("acc", 0, a);
    r = rnd();
    v = a;
    a = bm[r[9:0]];
    run(OP_XMAD, r[9:0], 3, pc + 14'h2);
    stored(v, r[9:0]);
    note("acc", 0, a);
    // b exchange with an x swap, then b load with a y swap
    ad = adr();
    v = b;
    b = bm[ad];
    op({OP_XMB, 2'b01});
    swp(2'b01);
    stored(v, ad);
    note("bReg", 1, b);
    b = bm[adr()];
    swp(2'b10);
    op({OP_LBM, 2'b10});
    note("bReg", 1, b);
    // status is one here, so the long branch is taken
    run({OP_LONG_BRANCH, 4'h5}, r[9:0], 3, {4'h5, r[9:0]});
    tend("exchange");
    for (k = 0; k < 4; k++) begin
      r = rnd();
      a = r[3:0];
      b = r[7:4];
      op({OP_LAI, a});
      op({OP_LBI, b});
      ta = {2'b00, r[11:8], b, a};
      rom[ta] = {k[1:0], r[19:12]};
      if (k[0]) {b, a} = r[19:12];
      if (k[1]) {ph, pl} = r[19:12];
      run({OP_PATTERN, r[11:8]}, 10'h0, 3, pc + 14'h1);
      note("acc", 0, a);
      note("bReg", 1, b);
      note("patternOutLow", 5, pl);
      note("patternOutHigh", 6, ph);
    end
    tend("pattern");
    r = rnd();
    a = r[3:0];
    b = r[7:4];
    op({OP_LAI, a});
    op({OP_LBI, b});
    run({OP_TABLE, r[11:8]}, 10'h0, 2, {2'b00, r[11:8], b, a});
    run({OP_CAL, r[17:12]}, 10'h0, 3, {8'h00, r[17:12]});
    op({OP_LAI, r[21:18]});
    note("acc", 0, r[21:18]);
    tend("table and zero page");
    repeat (2) @(negedge clk);
    results();
  end
endmodule
